// *** gcr_global_regs.sv ***
`timescale 1ns/100ps
module gcr_global_regs #(
	parameter logic [7:0] DEVICE_IDENTIFICATION_CODE  = 8'h5a, // Arbitrary value
	parameter logic [7:0] DEVICE_REV_CODE = 8'h01  // Arbitrary value
) (
	input  wire logic                   clk_sys_i,
	input  wire logic                   reset_n_i,
	input  wire logic                   config_mode_i,
	input  wire logic                   strap_base_i,
	input  wire gcr_pkg::gcr_host_req_t host_req_i,
	output logic [7:0]                  host_rdata_o,
	output logic                        host_rvalid_o,
	output logic [7:0]                  ldev_select_o,
	output logic [7:0]                  bank_index_o,
	output logic [7:0]                  bank_wdata_o,
	output logic                        bank_wr_o,
	output logic                        bank_rd_o,
	input  wire logic [7:0]             bank_rdata_i,
	output logic                        soft_reset_o,
	output logic [15:0]                 config_base_o,
	output gcr_pkg::gcr_ctrl_t          ctrl_o
);
	logic [7:0]  index_r;
	logic [7:0]  ldev_r;
	logic [7:0]  pwr_en_r;
	logic [7:0]  pwr_mgmt_r;
	logic [7:0]  osc_r;
	logic [7:0]  base_lo_r;
	logic [7:0]  base_hi_r;
	logic [15:0] base_act_r;
	logic [7:0]  test_r [5];
	logic        soft_rst_r;
	logic        strap_done_r;
	logic [7:0]  rdata_r;
	logic        rvalid_r;
	logic [7:0]  bwdata_r;
	logic [7:0]  bidx_r;
	logic        bwr_r;
	logic        brd_r;
	logic        sel_index;
	logic        sel_data;
	logic        data_wr;
	logic        data_rd;
	logic [7:0]  rd_mux;

	// ****************************************
	// Port decode
	// ****************************************
	// Index at base, data at base plus one, only in configuration mode
	assign sel_index = config_mode_i && (host_req_i.addr == config_base_o);
	assign sel_data  = config_mode_i && (host_req_i.addr == (config_base_o + 16'h0001));
	assign data_wr   = sel_data && host_req_i.wr;
	assign data_rd   = sel_data && host_req_i.rd;

	// Test register slot from index
	function automatic logic [2:0] test_slot(input logic [7:0] idx);
		test_slot = 3'(idx - gcr_pkg::IDX_TEST_D);
	endfunction : test_slot

	function automatic logic is_test(input logic [7:0] idx);
		is_test = (idx >= gcr_pkg::IDX_TEST_D) && (idx <= gcr_pkg::IDX_TEST_C);
	endfunction : is_test

	// Index register, full eight bits kept
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			index_r <= gcr_pkg::RST_INDEX_ADDRESS;
		end else if (sel_index && host_req_i.wr) begin
			index_r <= host_req_i.wdata;
		end
	end

	// Self-clearing soft reset pulse
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			soft_rst_r <= 1'b0;
		end else begin
			soft_rst_r <= data_wr && (index_r == gcr_pkg::IDX_CONFIG_CONTROL)
			              && host_req_i.wdata[gcr_pkg::SOFT_RESET_BIT];
		end
	end

	// ****************************************
	// Global registers cleared by soft reset, apart from the index, base and test registers
	// ****************************************
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ldev_r     <= gcr_pkg::RST_LOGICAL_DEV;
			pwr_en_r   <= gcr_pkg::RST_POWER;
			pwr_mgmt_r <= gcr_pkg::RST_POWER;
			osc_r      <= gcr_pkg::RST_OSC;
		end else if (soft_rst_r) begin
			ldev_r     <= gcr_pkg::RST_LOGICAL_DEV;
			pwr_en_r   <= gcr_pkg::RST_POWER;
			pwr_mgmt_r <= gcr_pkg::RST_POWER;
			osc_r      <= gcr_pkg::RST_OSC;
		end else if (data_wr) begin
			if (index_r == gcr_pkg::IDX_LOGICAL_DEV_SEL) begin
				ldev_r <= host_req_i.wdata;
			end else if (index_r == gcr_pkg::IDX_POWER_ENABLE) begin
				pwr_en_r <= host_req_i.wdata & gcr_pkg::POWER_MASK;
			end else if (index_r == gcr_pkg::IDX_POWER_MGMT) begin
				pwr_mgmt_r <= host_req_i.wdata & gcr_pkg::POWER_MASK;
			end else if (index_r == gcr_pkg::IDX_OSC_CONTROL) begin
				osc_r <= host_req_i.wdata & gcr_pkg::OSC_MASK;
			end
		end
	end

	// Test registers, kept for read-back only
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			for (int i = 0; i < 5; i++) begin
				test_r[i] <= gcr_pkg::RST_TEST;
			end
		end else if (data_wr && is_test(index_r)) begin
			test_r[test_slot(index_r)] <= host_req_i.wdata;
		end
	end

	// ****************************************
	// Relocatable configuration base
	// ****************************************
	// Strap caught after reset release; soft reset leaves base alone
	// Byte 0 only stages the low half; the live base moves on the byte 1 write
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			strap_done_r <= 1'b0;
			base_lo_r    <= gcr_pkg::RST_BASE_LOW_STRAP0;
			base_hi_r    <= gcr_pkg::RST_BASE_HIGH;
			base_act_r   <= {gcr_pkg::RST_BASE_HIGH, gcr_pkg::RST_BASE_LOW_STRAP0};
		end else if (!strap_done_r) begin
			strap_done_r <= 1'b1;
			base_lo_r    <= strap_base_i ? gcr_pkg::RST_BASE_LOW_STRAP1
			                             : gcr_pkg::RST_BASE_LOW_STRAP0;
			base_act_r   <= {gcr_pkg::RST_BASE_HIGH, strap_base_i ? gcr_pkg::RST_BASE_LOW_STRAP1
			                                                      : gcr_pkg::RST_BASE_LOW_STRAP0};
		end else if (data_wr && (index_r == gcr_pkg::IDX_BASE_LOW)) begin
			base_lo_r <= host_req_i.wdata & gcr_pkg::BASE_LOW_MASK;
		end else if (data_wr && (index_r == gcr_pkg::IDX_BASE_HIGH)) begin
			base_hi_r  <= host_req_i.wdata;
			base_act_r <= {host_req_i.wdata, base_lo_r};
		end
	end

	// Ports follow the base at once after the byte 1 write
	assign config_base_o = base_act_r;

	// ****************************************
	// Read path
	// ****************************************
	always_comb begin
		rd_mux = gcr_pkg::READ_ZERO;
		if (index_r == gcr_pkg::IDX_INDEX_ADDRESS) begin
			rd_mux = index_r;
		end else if (index_r == gcr_pkg::IDX_LOGICAL_DEV_SEL) begin
			rd_mux = ldev_r;
		end else if (index_r == gcr_pkg::IDX_DEVICE_IDENTIFICATION) begin
			rd_mux = DEVICE_IDENTIFICATION_CODE;
		end else if (index_r == gcr_pkg::IDX_DEVICE_REV) begin
			rd_mux = DEVICE_REV_CODE;
		end else if (index_r == gcr_pkg::IDX_POWER_ENABLE) begin
			rd_mux = pwr_en_r;
		end else if (index_r == gcr_pkg::IDX_POWER_MGMT) begin
			rd_mux = pwr_mgmt_r;
		end else if (index_r == gcr_pkg::IDX_OSC_CONTROL) begin
			rd_mux = osc_r;
		end else if (index_r == gcr_pkg::IDX_BASE_LOW) begin
			rd_mux = base_lo_r;
		end else if (index_r == gcr_pkg::IDX_BASE_HIGH) begin
			rd_mux = base_hi_r;
		end else if (is_test(index_r)) begin
			rd_mux = test_r[test_slot(index_r)];
		end else if (index_r >= gcr_pkg::IDX_BANK_FIRST) begin
			rd_mux = bank_rdata_i;
		end
	end

	// Registered read data, one cycle after the strobe
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rdata_r  <= gcr_pkg::READ_ZERO;
			rvalid_r <= 1'b0;
		end else begin
			rvalid_r <= (sel_index || sel_data) && host_req_i.rd;
			if (sel_index && host_req_i.rd) begin
				rdata_r <= index_r;
			end else if (data_rd) begin
				rdata_r <= rd_mux;
			end
		end
	end

	// ****************************************
	// Banked register forwarding
	// ****************************************
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			bidx_r   <= gcr_pkg::READ_ZERO;
			bwdata_r <= gcr_pkg::READ_ZERO;
			bwr_r    <= 1'b0;
			brd_r    <= 1'b0;
		end else begin
			bidx_r   <= index_r;
			bwdata_r <= host_req_i.wdata;
			bwr_r    <= data_wr && (index_r >= gcr_pkg::IDX_BANK_FIRST);
			brd_r    <= data_rd && (index_r >= gcr_pkg::IDX_BANK_FIRST);
		end
	end

	assign host_rdata_o  = rdata_r;
	assign host_rvalid_o = rvalid_r;
	assign ldev_select_o = ldev_r;
	assign bank_index_o  = bidx_r;
	assign bank_wdata_o  = bwdata_r;
	assign bank_wr_o     = bwr_r;
	assign bank_rd_o     = brd_r;
	assign soft_reset_o  = soft_rst_r;

	// ****************************************
	// Decoded controls
	// ****************************************
	always_comb begin
		ctrl_o.power_enable = {pwr_en_r[gcr_pkg::PWR_SERIAL2_BIT], pwr_en_r[gcr_pkg::PWR_SERIAL1_BIT],
		                       pwr_en_r[gcr_pkg::PWR_PARALLEL_BIT], pwr_en_r[gcr_pkg::PWR_FLOPPY_BIT]};
		ctrl_o.power_mgmt   = {pwr_mgmt_r[gcr_pkg::PWR_SERIAL2_BIT], pwr_mgmt_r[gcr_pkg::PWR_SERIAL1_BIT],
		                       pwr_mgmt_r[gcr_pkg::PWR_PARALLEL_BIT], pwr_mgmt_r[gcr_pkg::PWR_FLOPPY_BIT]};
		ctrl_o.pll_run      = !osc_r[gcr_pkg::OSC_PLL_OFF_BIT];
		ctrl_o.osc_run      = osc_r[gcr_pkg::OSC_CODE_LSB +: 2] != gcr_pkg::OSC_CODE_STOP;
		ctrl_o.baud_generator_clock_run = osc_r[gcr_pkg::OSC_CODE_LSB +: 2] != gcr_pkg::OSC_CODE_STOP;
		ctrl_o.rtc_interrupt_line_active_low = osc_r[gcr_pkg::OSC_IRQ_POL_BIT];
	end
endmodule : gcr_global_regs

// *** gcr_pkg.sv ***
// Overview of operation
// - All eight index bits select a register; upper bits never alias.
// - Unimplemented indices and bits ignore writes and read back zero.
// - Host writes index port first, then data port reaches indexed register.
// - Port accesses are ignored unless configuration mode is active.
// - Bit 0 of control register triggers soft reset and self-clears.
// - Logical device select picks the bank for indices 0x30 and above.
// - Identification register is read-only with a fixed code.
// - Revision register is read-only with a fixed code.
// - Power enable bits 0,3,4,5 switch floppy, parallel, serial functions.
// - Power management holds bits 0,3,4,5; bits 6 and 7 read zero.
// - Oscillator bit 1 stops the PLL when set.
// - Oscillator code 11 in bits 3:2 stops oscillator and baud clock.
// - Oscillator register resets to 0x04 on hard reset.
// - Base byte 0 holds address bits 7:1, bit 0 zero; byte 1 bits 15:8.
// - Default base is 3F0 with strap low, 370 with strap high.
// - Ports move to new base as soon as byte 1 is written.
// - Configuration base is always even.
// - Base returns to default only on hard reset, never soft reset.
// - Indices 0x30 and above are banked by logical device select.
package gcr_pkg;
	// ****************************************
	// Register indices
	// ****************************************
	localparam logic [7:0] IDX_CONFIG_CONTROL    = 8'h02;
	localparam logic [7:0] IDX_INDEX_ADDRESS     = 8'h03;
	localparam logic [7:0] IDX_LOGICAL_DEV_SEL   = 8'h07;
	localparam logic [7:0] IDX_DEVICE_IDENTIFICATION         = 8'h20;
	localparam logic [7:0] IDX_DEVICE_REV        = 8'h21;
	localparam logic [7:0] IDX_POWER_ENABLE      = 8'h22;
	localparam logic [7:0] IDX_POWER_MGMT        = 8'h23;
	localparam logic [7:0] IDX_OSC_CONTROL       = 8'h24;
	localparam logic [7:0] IDX_BASE_LOW          = 8'h26;
	localparam logic [7:0] IDX_BASE_HIGH         = 8'h27;
	localparam logic [7:0] IDX_TEST_D            = 8'h2b;
	localparam logic [7:0] IDX_TEST_E            = 8'h2c;
	localparam logic [7:0] IDX_TEST_A            = 8'h2d;
	localparam logic [7:0] IDX_TEST_B            = 8'h2e;
	localparam logic [7:0] IDX_TEST_C            = 8'h2f;
	localparam logic [7:0] IDX_BANK_FIRST        = 8'h30;
	// ****************************************
	// Field positions and masks
	// ****************************************
	localparam int         SOFT_RESET_BIT        = 0;
	localparam logic [7:0] POWER_MASK            = 8'h39;
	localparam int         PWR_FLOPPY_BIT        = 0;
	localparam int         PWR_PARALLEL_BIT      = 3;
	localparam int         PWR_SERIAL1_BIT       = 4;
	localparam int         PWR_SERIAL2_BIT       = 5;
	localparam logic [7:0] OSC_MASK              = 8'h8e;
	localparam int         OSC_PLL_OFF_BIT       = 1;
	localparam int         OSC_CODE_LSB          = 2;
	localparam logic [1:0] OSC_CODE_STOP         = 2'h3;
	localparam int         OSC_IRQ_POL_BIT       = 7;
	localparam logic [7:0] BASE_LOW_MASK         = 8'hfe;
	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [7:0] RST_INDEX_ADDRESS     = 8'h03;
	localparam logic [7:0] RST_LOGICAL_DEV       = 8'h00;
	localparam logic [7:0] RST_POWER             = 8'h00;
	localparam logic [7:0] RST_OSC               = 8'h04;
	localparam logic [7:0] RST_BASE_LOW_STRAP0   = 8'hf0;
	localparam logic [7:0] RST_BASE_LOW_STRAP1   = 8'h70;
	localparam logic [7:0] RST_BASE_HIGH         = 8'h03;
	localparam logic [7:0] RST_TEST              = 8'h00;
	localparam logic [7:0] READ_ZERO             = 8'h00;

	// Host port strobe group
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic        wr;
		logic        rd;
	} gcr_host_req_t;

	// Decoded control outputs
	typedef struct packed {
		logic [3:0] power_enable;
		logic [3:0] power_mgmt;
		logic       pll_run;
		logic       osc_run;
		logic       baud_generator_clock_run;
		logic       rtc_interrupt_line_active_low;
	} gcr_ctrl_t;
endpackage : gcr_pkg

// *** gcr_bank_model.sv ***
`timescale 1ns/100ps
module gcr_bank_model (
	input  wire logic       clk_sys_i,
	input  wire logic [7:0] ldev_select_i,
	input  wire logic       bank_wr_i,
	input  wire logic [7:0] bank_wdata_i,
	output logic [7:0]      bank_rdata_o
);
	logic [7:0] bank_r [2];
	// ****************
	// One register for each value of device select bit 0, two in all
	// ****************
	always_ff @(posedge clk_sys_i) begin
		if (bank_wr_i) begin
			bank_r[ldev_select_i[0]] <= bank_wdata_i;
		end
	end
	// Read data follows the selected device
	assign bank_rdata_o = bank_r[ldev_select_i[0]];
endmodule : gcr_bank_model

// *** gcr_global_regs_properties.sv ***
`timescale 1ns/100ps
module gcr_global_regs_checker (
	input wire logic               clk_sys_i,
	input wire logic               reset_n_i,
	input wire logic               config_mode_i,
	input wire gcr_pkg::gcr_host_req_t host_req_i,
	input wire logic               host_rvalid_o,
	input wire logic [7:0]         ldev_select_o,
	input wire logic [7:0]         bank_index_o,
	input wire logic               bank_wr_o,
	input wire logic               bank_rd_o,
	input wire logic               soft_reset_o,
	input wire logic [15:0]        config_base_o,
	input wire gcr_pkg::gcr_ctrl_t ctrl_o
);
	// ****************
	// Port rules
	// ****************
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!reset_n_i);
	read_answer_a: assert property (host_rvalid_o |-> $past(host_req_i.rd && config_mode_i &&
		(host_req_i.addr == config_base_o || host_req_i.addr == config_base_o + 16'h1))) else $error("Read answer without read");
	read_accept_a: assert property (config_mode_i && host_req_i.rd && host_req_i.addr == config_base_o + 16'h1
		|=> host_rvalid_o) else $error("Accepted read got no answer");
	mode_off_a: assert property (!config_mode_i |=> !host_rvalid_o && !bank_wr_o && !bank_rd_o && !soft_reset_o)
		else $error("Access taken outside configuration mode");
	base_even_a: assert property (config_base_o[0] == 1'b0) else $error("Odd configuration base");
	soft_clear_a: assert property (soft_reset_o |=> !soft_reset_o) else $error("Soft reset did not self clear");
	soft_values_a: assert property (soft_reset_o |=> ldev_select_o == 8'h00 && ctrl_o.power_enable == 4'h0
		&& ctrl_o.osc_run && ctrl_o.pll_run) else $error("Soft reset values not loaded");
	soft_base_a: assert property (soft_reset_o |=> $stable(config_base_o) [*2]) else $error("Soft reset moved base");
	bank_range_a: assert property (bank_wr_o || bank_rd_o |-> bank_index_o >= 8'h30) else $error("Bank access below 0x30");
	base_move_a: assert property ($past(reset_n_i, 2) && $changed(config_base_o) |-> $past(host_req_i.wr &&
		config_mode_i && host_req_i.addr == config_base_o + 16'h1)) else $error("Base moved without data write");
	soft_cov: cover property (soft_reset_o);
	bank_cov: cover property (bank_wr_o);
	move_cov: cover property ($past(reset_n_i, 2) && $changed(config_base_o));
endmodule : gcr_global_regs_checker
bind gcr_global_regs gcr_global_regs_checker chk_i (.clk_sys_i, .reset_n_i, .config_mode_i, .host_req_i, .host_rvalid_o,
	.ldev_select_o, .bank_index_o, .bank_wr_o, .bank_rd_o, .soft_reset_o, .config_base_o, .ctrl_o);

// *** tb_top.sv ***
`timescale 1ns/100ps
module tb_top;
	logic                   clk_sys_i     = 1'b0;
	logic                   reset_n_i     = 1'b0;
	logic                   config_mode_i = 1'b1;
	logic                   strap_base_i  = 1'b0;
	gcr_pkg::gcr_host_req_t host_req_i    = '0;
	logic [7:0]             host_rdata_o, ldev_select_o, bank_index_o, bank_wdata_o, bank_rdata_i;
	logic                   host_rvalid_o, bank_wr_o, bank_rd_o, soft_reset_o;
	logic [15:0]            config_base_o, base;
	gcr_pkg::gcr_ctrl_t     ctrl_o;
	int                     fails = 0;
	int                     samples_checked = 0;
	logic [7:0] rst_idx [11] = '{8'h02, 8'h03, 8'h07, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h26, 8'h27, 8'h2f};
	logic [7:0] rst_val [11] = '{8'h00, 8'h03, 8'h00, 8'h5a, 8'h01, 8'h00, 8'h00, 8'h04, 8'hf0, 8'h03, 8'h00};
	logic [7:0] unimp [6] = '{8'h00, 8'h01, 8'h08, 8'h1f, 8'h25, 8'h28};
	logic [7:0] msk_idx [5] = '{8'h22, 8'h23, 8'h24, 8'h20, 8'h21};
	logic [7:0] msk_val [5] = '{8'h39, 8'h39, 8'h8e, 8'h5a, 8'h01};
	// ****************
	// Clock, design and bank model
	// ****************
	always #25 clk_sys_i = ~clk_sys_i;
	gcr_global_regs dut (.clk_sys_i, .reset_n_i, .config_mode_i, .strap_base_i, .host_req_i, .host_rdata_o,
		.host_rvalid_o, .ldev_select_o, .bank_index_o, .bank_wdata_o, .bank_wr_o, .bank_rd_o, .bank_rdata_i,
		.soft_reset_o, .config_base_o, .ctrl_o);
	gcr_bank_model bank (.clk_sys_i, .ldev_select_i(ldev_select_o), .bank_wr_i(bank_wr_o),
		.bank_wdata_i(bank_wdata_o), .bank_rdata_o(bank_rdata_i));
	// ****************
	// Host access tasks
	// ****************
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic bus(input logic [15:0] a, input logic [7:0] d, input logic w);
		@(posedge clk_sys_i);
		host_req_i <= '{a, d, w, !w};
		@(posedge clk_sys_i);
		host_req_i <= '0;
		#1;
	endtask : bus
	task automatic cfg_wr(input logic [7:0] idx, input logic [7:0] d);
		bus(base, idx, 1'b1);
		bus(base + 16'h1, d, 1'b1);
	endtask : cfg_wr
	task automatic cfg_rd(input logic [7:0] idx, input logic [7:0] exp, input string what);
		bus(base, idx, 1'b1);
		bus(base + 16'h1, 8'h00, 1'b0);
		chk({what, " valid"}, 16'h1, {15'h0, host_rvalid_o});
		chk(what, {8'h0, exp}, {8'h0, host_rdata_o});
	endtask : cfg_rd
	task automatic hard_reset(input logic strap);
		@(posedge clk_sys_i);
		reset_n_i <= 1'b0;
		strap_base_i <= strap;
		repeat (6) @(posedge clk_sys_i);
		reset_n_i <= 1'b1;
		repeat (2) @(posedge clk_sys_i);
		#1;
	endtask : hard_reset
	task automatic print_verdict;
		$display("Counts: %0d compared, %0d mismatched", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : print_verdict
	// ****************
	// Test sequence, test registers never written
	// ****************
	initial begin
		hard_reset(1'b0);
		base = 16'h03f0;
		chk("default base", 16'h03f0, config_base_o);
		foreach (rst_idx[i]) cfg_rd(rst_idx[i], rst_val[i], "reset value");
		$display("Test done: reset values");
		foreach (unimp[i]) begin
			cfg_wr(unimp[i], 8'hff);
			cfg_rd(unimp[i], 8'h00, "unimplemented");
		end
		$display("Test done: unimplemented indices");
		foreach (msk_idx[i]) begin
			cfg_wr(msk_idx[i], 8'hff);
			cfg_rd(msk_idx[i], msk_val[i], "bit mask");
		end
		chk("controls all set", 16'h0ff1, {4'h0, ctrl_o});
		for (int c = 0; c < 4; c++) begin
			cfg_wr(8'h24, 8'(c << 2));
			chk("osc decode", {12'h0, 1'b1, c != 3, c != 3, 1'b0}, {12'h0, ctrl_o[3:0]});
		end
		$display("Test done: field masks");
		@(posedge clk_sys_i);
		config_mode_i <= 1'b0;
		cfg_wr(8'h22, 8'h00);
		@(posedge clk_sys_i);
		config_mode_i <= 1'b1;
		cfg_rd(8'h22, 8'h39, "mode off ignored");
		$display("Test done: configuration mode");
		cfg_wr(8'h26, 8'h35);
		chk("base after low byte", 16'h03f0, config_base_o);
		cfg_wr(8'h27, 8'h12);
		chk("base after high byte", 16'h1234, config_base_o);
		base = 16'h1234;
		cfg_rd(8'h26, 8'h34, "base low byte");
		bus(16'h03f0, 8'h22, 1'b1);
		bus(16'h03f1, 8'h00, 1'b1);
		cfg_rd(8'h22, 8'h39, "old base ignored");
		$display("Test done: relocation");
		cfg_wr(8'h07, 8'h01);
		cfg_wr(8'h30, 8'h01);
		cfg_wr(8'h07, 8'h00);
		cfg_wr(8'h30, 8'h00);
		cfg_wr(8'h07, 8'h01);
		cfg_rd(8'h30, 8'h01, "bank of device one");
		$display("Test done: logical device banks");
		cfg_wr(8'h02, 8'h01);
		repeat (2) @(posedge clk_sys_i);
		cfg_rd(8'h22, 8'h00, "power after soft reset");
		cfg_rd(8'h07, 8'h00, "device after soft reset");
		cfg_rd(8'h24, 8'h04, "osc after soft reset");
		cfg_rd(8'h27, 8'h12, "base kept");
		cfg_rd(8'h02, 8'h00, "control cleared");
		$display("Test done: soft reset");
		hard_reset(1'b1);
		chk("strap base", 16'h0370, config_base_o);
		base = 16'h0370;
		cfg_rd(8'h26, 8'h70, "strap low byte");
		$display("Test done: strap and hard reset");
		print_verdict();
	end
	// Hang guard
	initial begin
		repeat (20000) @(posedge clk_sys_i);
		fails++;
		print_verdict();
	end
endmodule : tb_top
